/* File: verilog/atc_pkg.sv */
`default_nettype none
package atc_pkg;
   // geometry
   localparam int CHANNELS = 4;
   localparam int SMP_W = 24;
   localparam int ADDR_W = 8;
   localparam int FIFO_DEPTH_DEF = 16;
   localparam int STORE_SAMPLES_DEF = 1500000000;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_COUNT = 8'h08;
   localparam logic [7:0] OFF_PERIOD = 8'h0c;
   localparam logic [7:0] OFF_HIGH = 8'h10;
   localparam logic [7:0] OFF_LOW = 8'h14;
   localparam logic [7:0] OFF_RANGE = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam logic [7:0] OFF_STORED = 8'h20;

   // control fields
   localparam int CTRL_W = 6;
   localparam int CTRL_MODE = 0;
   localparam int CTRL_TSRC = 1;
   localparam int CTRL_COND = 2;
   localparam int CTRL_CHAN = 4;
   localparam logic [1:0] COND_ABOVE = 2'h0;
   localparam logic [1:0] COND_BELOW = 2'h1;
   localparam logic [1:0] COND_LEAVE = 2'h2;
   localparam logic [1:0] COND_ENTER = 2'h3;

   // command bits
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_XFER = 2;
   localparam int CMD_CLR = 3;

   // status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_OVR = 2;
   localparam int STAT_TRIG = 3;
   localparam int STAT_STATE = 4;

   // reset values
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [30:0] COUNT_RST = 31'h1;
   localparam logic [23:0] HIGH_RST = 24'h000000;
   localparam logic [23:0] LOW_RST = 24'h000000;
   localparam logic [15:0] RANGE_RST = 16'h0000;
   localparam logic [3:0] RANGE_MAX = 4'h9;

   // sample rate limits
   localparam int CLK_HZ = 20000000;
   localparam int CONT_MAX_HZ = 60000;
   localparam int BUF_MAX_HZ = 128000;
   localparam logic [15:0] PER_CONT_MIN =
      16'((CLK_HZ + CONT_MAX_HZ - 1) / CONT_MAX_HZ);
   localparam logic [15:0] PER_BUF_MIN =
      16'((CLK_HZ + BUF_MAX_HZ - 1) / BUF_MAX_HZ);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARMED,
      ST_RUN,
      ST_HOLD,
      ST_XFER
   } atc_state_e;
endpackage
`default_nettype wire

/* File: verilog/atc_top.sv */
`default_nettype none
// word buffer between sequencer and host stream
module atc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clock, // system clock
   input wire logic rst, // sync reset
   input wire logic inValid, // push request
   input wire logic [WIDTH-1:0] inData, // push word
   output logic inReady, // room left
   output logic outValid, // word available
   output logic [WIDTH-1:0] outData, // head word
   input wire logic outReady // pop request
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] cnt_q;
   wire doPush = inValid & inReady;
   wire doPop = outValid & outReady;

   // honest flags from the occupancy count
   assign inReady = cnt_q != (AW + 1)'(DEPTH);
   assign outValid = cnt_q != '0;
   assign outData = mem[rdPtr_q];

   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (doPush) wrPtr_q <= wrap(wrPtr_q);
         if (doPop) rdPtr_q <= wrap(rdPtr_q);
         cnt_q <= cnt_q + (AW + 1)'(doPush) - (AW + 1)'(doPop);
      end
   end
endmodule

// Notes on behaviour
// [R01] Continuous mode forwards every sample to the host at up to 60 kHz; the code drops words and sets overflow while the stream fifo is full.
// [R02] Buffered N-sample mode runs at per-channel rates up to 128 kHz.
// [R03] Buffered samples stay in the store until the host commands transfer.
// [R04] The sample store holds up to 1500 million samples.
// [R05] Software trigger starts acquisition only on the host start command.
// [R06] Threshold trigger compares one chosen channel with high and low.
// [R07] Above-high starts when the channel is above high, then N samples.
// [R08] Below-low starts when the channel is below low, then N samples.
// [R09] Leave-window starts when the channel goes from inside to outside.
// [R10] Enter-window starts when the channel goes from outside to inside.
// [R11] Each channel has a range code choosing one of ten spans.
// [R12] A threshold trigger fires once per arming and then is ignored.
// [R13] N comes from a host register and completion is flagged at N.
module atc_top
   import atc_pkg::*;
#(
   parameter int STORE_SAMPLES = STORE_SAMPLES_DEF, // store capacity
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF // stream buffer words
) (
   input wire logic clock, // 20 MHz
   input wire logic rst, // sync, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output logic convStart, // converter start pulse
   input wire logic sampleValid, // four samples ready
   input wire logic [SMP_W-1:0] sampleCh0, // channel 0 sample
   input wire logic [SMP_W-1:0] sampleCh1, // channel 1 sample
   input wire logic [SMP_W-1:0] sampleCh2, // channel 2 sample
   input wire logic [SMP_W-1:0] sampleCh3, // channel 3 sample
   output logic [15:0] rangeSel, // range codes, 4 bits each
   output logic memWrEn, // store write pulse
   output logic [30:0] memWrAddr, // store write address
   output logic [31:0] memWrData, // store write word
   output logic memRdEn, // store read pulse
   output logic [30:0] memRdAddr, // store read address
   input wire logic memRdValid, // store read answer
   input wire logic [31:0] memRdData, // store read word
   output logic hostValid, // stream word valid
   output logic [31:0] hostData, // stream word
   input wire logic hostReady, // host accepts word
   output logic acqBusy, // acquisition running
   output logic acqDone // n samples stored
);
   localparam logic [30:0] SETS_MAX = 31'(STORE_SAMPLES / CHANNELS);

   atc_state_e state_q, stateD;
   logic [CTRL_W-1:0] ctrl_q;
   logic [30:0] count_q;
   logic [15:0] period_q;
   logic [SMP_W-1:0] high_q, low_q;
   logic [15:0] range_q;
   logic done_q, ovr_q, trig_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic [15:0] perCnt_q;
   logic convStart_q, acqBusy_q;
   logic [SMP_W-1:0] hold_q [CHANNELS];
   logic [1:0] pushIdx_q;
   logic pushing_q, runBuf_q;
   logic prevIn_q, prevValid_q;
   logic [30:0] setCnt_q, wrAddr_q, rdAddr_q, rdAddr2_q;
   logic rdOut_q, memWrEn_q, memRdEn_q;
   logic [31:0] memWrData_q;
   logic [30:0] memWrAddr_q;
   logic hostValid_q;
   logic [31:0] hostData_q;
   logic [SMP_W-1:0] smp [CHANNELS];

   assign smp[0] = sampleCh0;
   assign smp[1] = sampleCh1;
   assign smp[2] = sampleCh2;
   assign smp[3] = sampleCh3;

   // keep old code for any field above the last legal span
   function automatic logic [15:0] rangeMerge(input logic [15:0] cur,
                                              input logic [15:0] wr);
      logic [15:0] r;
      r = cur;
      for (int i = 0; i < CHANNELS; i++) begin
         if (wr[i*4 +: 4] <= RANGE_MAX) r[i*4 +: 4] = wr[i*4 +: 4];
      end
      return r;
   endfunction

   // apb decode; zero wait states, answer in the first access cycle
   wire setup = psel & ~penable;
   wire wrEn = psel & penable & pready_q & pwrite;
   wire hitCtrl = paddr == OFF_CTRL;
   wire hitCmd = paddr == OFF_CMD;
   wire hitCount = paddr == OFF_COUNT;
   wire hitPeriod = paddr == OFF_PERIOD;
   wire hitHigh = paddr == OFF_HIGH;
   wire hitLow = paddr == OFF_LOW;
   wire hitRange = paddr == OFF_RANGE;
   wire hitStatus = paddr == OFF_STATUS;
   wire hitStored = paddr == OFF_STORED;
   wire mapped = hitCtrl | hitCmd | hitCount | hitPeriod | hitHigh |
      hitLow | hitRange | hitStatus | hitStored;
   wire [31:0] statusWord = {25'h0, 3'(state_q), trig_q, ovr_q, done_q,
      state_q != ST_IDLE};
   wire [31:0] rdMux =
      hitCtrl ? {26'h0, ctrl_q} :
      hitCount ? {1'h0, count_q} :
      hitPeriod ? {16'h0, period_q} :
      hitHigh ? {8'h0, high_q} :
      hitLow ? {8'h0, low_q} :
      hitRange ? {16'h0, range_q} :
      hitStatus ? statusWord :
      hitStored ? {1'h0, wrAddr_q} : 32'h0;

   // command strobes, one cycle each
   wire cmdWr = wrEn & hitCmd;
   wire cmdStart = cmdWr & pwdata[CMD_START]; // [R05]
   wire cmdStop = cmdWr & pwdata[CMD_STOP];
   wire cmdXfer = cmdWr & pwdata[CMD_XFER]; // [R03]
   wire cmdClr = cmdWr & pwdata[CMD_CLR];
   wire [30:0] nWr = pwdata[30:0];

   // threshold forces buffered mode, continuous needs a software start
   wire trigThr = ctrl_q[CTRL_TSRC];
   wire bufMode = ctrl_q[CTRL_MODE] | trigThr;
   wire [15:0] perMin = bufMode ? PER_BUF_MIN : PER_CONT_MIN; // [R01] [R02]
   wire [15:0] perEff = (period_q < perMin) ? perMin : period_q;
   wire tick = (state_q == ST_RUN || state_q == ST_ARMED) &&
      perCnt_q == 16'(perEff - 16'h1);

   // window compare on the monitored channel, band is inclusive
   wire [SMP_W-1:0] monVal = smp[ctrl_q[CTRL_CHAN +: 2]]; // [R06]
   wire isAbove = $signed(monVal) > $signed(high_q);
   wire isBelow = $signed(monVal) < $signed(low_q);
   wire isIn = ~isAbove & ~isBelow;
   wire [1:0] cond = ctrl_q[CTRL_COND +: 2];
   wire condHit =
      (cond == COND_ABOVE) ? isAbove : // [R07]
      (cond == COND_BELOW) ? isBelow : // [R08]
      (cond == COND_LEAVE) ? prevValid_q & prevIn_q & ~isIn : // [R09]
      prevValid_q & ~prevIn_q & isIn; // [R10]
   wire fire = state_q == ST_ARMED && sampleValid && condHit; // [R12]
   wire accept = sampleValid && (state_q == ST_RUN || fire);
   wire lastSet = runBuf_q && (setCnt_q + 31'h1 >= count_q); // [R13]

   // sample word carries its channel number above the data
   wire [31:0] pushWord = {6'h0, pushIdx_q, hold_q[pushIdx_q]};
   wire fifoInReady, fifoOutValid;
   wire xferOn = state_q == ST_XFER;
   wire issueRd = xferOn && !rdOut_q && rdAddr_q != wrAddr_q && fifoInReady;
   wire xferDone = rdAddr_q == wrAddr_q && !rdOut_q;
   wire fifoInValid = xferOn ? (memRdValid & rdOut_q)
      : (pushing_q & ~runBuf_q);
   wire [31:0] fifoInData = xferOn ? memRdData : pushWord;
   wire [31:0] fifoOutData;
   wire fifoOutReady = ~hostValid_q | hostReady;
   wire dropWord = pushing_q & ~runBuf_q & ~fifoInReady & ~xferOn;

   // sequencer
   always_comb begin
      stateD = state_q;
      unique case (state_q)
         ST_IDLE:
            if (cmdStart) stateD = trigThr ? ST_ARMED : ST_RUN; // [R05]
         ST_ARMED:
            if (cmdStop) stateD = ST_IDLE;
            else if (fire) stateD = lastSet ? ST_HOLD : ST_RUN; // [R12]
         ST_RUN:
            if (cmdStop) stateD = ST_IDLE;
            else if (accept && lastSet) stateD = ST_HOLD; // [R13]
         ST_HOLD:
            if (cmdStop) stateD = ST_IDLE;
            else if (cmdStart) stateD = trigThr ? ST_ARMED : ST_RUN;
            else if (cmdXfer && !pushing_q) stateD = ST_XFER; // [R03]
         ST_XFER:
            if (cmdStop || xferDone) stateD = ST_IDLE;
         default: stateD = ST_IDLE;
      endcase
   end

   // software registers
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         count_q <= COUNT_RST;
         period_q <= PER_CONT_MIN;
         high_q <= HIGH_RST;
         low_q <= LOW_RST;
         range_q <= RANGE_RST;
      end else if (wrEn) begin
         if (hitCtrl) ctrl_q <= pwdata[CTRL_W-1:0];
         if (hitCount) count_q <= (nWr > SETS_MAX) ? SETS_MAX : nWr; // [R04]
         if (hitPeriod) period_q <= pwdata[15:0];
         if (hitHigh) high_q <= pwdata[SMP_W-1:0];
         if (hitLow) low_q <= pwdata[SMP_W-1:0];
         if (hitRange) range_q <= rangeMerge(range_q, pwdata[15:0]); // [R11]
      end
   end

   // apb answer; sticky flags, a set in the clear cycle wins
   always_ff @(posedge clock) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
         done_q <= 1'b0;
         ovr_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q <= (setup & ~pwrite) ? rdMux : 32'h0;
         done_q <= (done_q & ~cmdClr & ~cmdStart) |
            (stateD == ST_HOLD && state_q != ST_HOLD); // [R13]
         ovr_q <= (ovr_q & ~cmdClr) | dropWord | (accept & pushing_q);
         trig_q <= (trig_q & ~cmdClr) | fire;
      end
   end

   // pacing, capture and trigger history
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_IDLE;
         perCnt_q <= 16'h0;
         convStart_q <= 1'b0;
         acqBusy_q <= 1'b0;
         pushing_q <= 1'b0;
         pushIdx_q <= 2'h0;
         runBuf_q <= 1'b0;
         prevIn_q <= 1'b0;
         prevValid_q <= 1'b0;
         setCnt_q <= 31'h0;
      end else begin
         state_q <= stateD;
         perCnt_q <= (tick || stateD != state_q) ? 16'h0 : perCnt_q + 16'h1;
         // no start may leave in the cycle a stop lands in
         convStart_q <= tick && !cmdStop; // [R01] [R02]
         acqBusy_q <= stateD != ST_IDLE;
         if (accept) begin
            pushing_q <= 1'b1;
            pushIdx_q <= 2'h0;
         end else if (pushing_q) begin
            pushing_q <= pushIdx_q != 2'h3;
            pushIdx_q <= pushIdx_q + 2'h1;
         end
         if (cmdStart) begin
            runBuf_q <= bufMode;
            prevValid_q <= 1'b0;
         end else if (state_q == ST_ARMED && sampleValid) begin
            prevIn_q <= isIn;
            prevValid_q <= 1'b1;
         end
         if (cmdStart) setCnt_q <= 31'h0;
         else if (accept) setCnt_q <= setCnt_q + 31'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (accept) begin
         for (int i = 0; i < CHANNELS; i++) hold_q[i] <= smp[i];
      end
   end

   // store write and read-back; one read outstanding so the fifo has room
   always_ff @(posedge clock) begin
      if (rst) begin
         wrAddr_q <= 31'h0;
         rdAddr_q <= 31'h0;
         rdAddr2_q <= 31'h0;
         rdOut_q <= 1'b0;
         memWrEn_q <= 1'b0;
         memWrAddr_q <= 31'h0;
         memWrData_q <= 32'h0;
         memRdEn_q <= 1'b0;
      end else begin
         memWrEn_q <= pushing_q & runBuf_q; // [R03]
         memWrAddr_q <= wrAddr_q;
         memWrData_q <= pushWord;
         if (cmdStart) wrAddr_q <= 31'h0;
         else if (pushing_q & runBuf_q) wrAddr_q <= wrAddr_q + 31'h1;
         memRdEn_q <= issueRd;
         if (issueRd) rdAddr2_q <= rdAddr_q;
         if (state_q != ST_XFER) rdAddr_q <= 31'h0;
         else if (issueRd) rdAddr_q <= rdAddr_q + 31'h1;
         rdOut_q <= xferOn & (issueRd | (rdOut_q & ~memRdValid));
      end
   end

   atc_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) streamFifo (
      .clock(clock),
      .rst(rst),
      .inValid(fifoInValid),
      .inData(fifoInData),
      .inReady(fifoInReady),
      .outValid(fifoOutValid),
      .outData(fifoOutData),
      .outReady(fifoOutReady)
   );

   // registered stream output stage
   always_ff @(posedge clock) begin
      if (rst) begin
         hostValid_q <= 1'b0;
         hostData_q <= 32'h0;
      end else if (fifoOutReady) begin
         hostValid_q <= fifoOutValid;
         if (fifoOutValid) hostData_q <= fifoOutData;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign convStart = convStart_q;
   assign rangeSel = range_q;
   assign memWrEn = memWrEn_q;
   assign memWrAddr = memWrAddr_q;
   assign memWrData = memWrData_q;
   assign memRdEn = memRdEn_q;
   assign memRdAddr = rdAddr2_q;
   assign hostValid = hostValid_q;
   assign hostData = hostData_q;
   assign acqBusy = acqBusy_q;
   assign acqDone = done_q;
endmodule
`default_nettype wire

/* File: testbench/atc_top_chk.sv */
`default_nettype none
module atc_top_chk
   import atc_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst, // sync reset
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic pready, // apb ready
   input wire logic convStart, // converter start
   input wire logic [15:0] rangeSel, // range codes
   input wire logic memWrEn, // store write
   input wire logic [30:0] memWrAddr, // store address
   input wire logic memRdEn, // store read
   input wire logic hostValid, // stream valid
   input wire logic [31:0] hostData, // stream word
   input wire logic hostReady, // host accepts
   input wire logic acqBusy, // running
   input wire logic acqDone // done flag
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   logic [15:0] gapCnt_q;
   logic gapOk_q;
   logic xferSeen_q;
   wire cmdWr = psel && penable && pready && pwrite && paddr == OFF_CMD;
   // gap between starts, only within one run so a restart cannot trip it
   always_ff @(posedge clock) begin
      if (rst || !acqBusy) begin
         gapCnt_q <= 16'h0000;
         gapOk_q <= 1'b0;
      end else if (convStart) begin
         gapCnt_q <= 16'h0001;
         gapOk_q <= 1'b1;
      end else if (gapCnt_q != 16'hffff) begin
         gapCnt_q <= gapCnt_q + 16'h0001;
      end
   end
   // remembers a transfer command until the run ends
   always_ff @(posedge clock) begin
      if (rst) begin
         xferSeen_q <= 1'b0;
      end else if (cmdWr && pwdata[CMD_XFER]) begin
         xferSeen_q <= 1'b1;
      end else if (!acqBusy) begin
         xferSeen_q <= 1'b0;
      end
   end
   chk_ready_pulse: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("apb ready not a single cycle after setup");
   chk_range_legal: assert property (
      rangeSel[3:0] <= RANGE_MAX && rangeSel[7:4] <= RANGE_MAX &&
      rangeSel[11:8] <= RANGE_MAX && rangeSel[15:12] <= RANGE_MAX)
      else $error("range code above nine");
   chk_start_busy: assert property (
      cmdWr && pwdata[CMD_START] && !pwdata[CMD_STOP] |=> acqBusy)
      else $error("start command did not begin acquisition");
   chk_conv_busy: assert property (convStart |-> acqBusy)
      else $error("conversion while idle");
   chk_conv_gap: assert property (
      convStart && gapOk_q |-> gapCnt_q >= PER_BUF_MIN)
      else $error("sample rate above limit");
   chk_write_burst: assert property (
      $rose(memWrEn) |-> memWrEn [*4] ##1 !memWrEn)
      else $error("store burst not four words");
   chk_addr_step: assert property (
      memWrEn && $past(memWrEn) |-> memWrAddr == $past(memWrAddr) + 31'h1)
      else $error("store address not consecutive");
   chk_read_after: assert property (
      memRdEn |-> xferSeen_q && !memWrEn)
      else $error("store read without transfer command");
   chk_stream_hold: assert property (
      hostValid && !hostReady |=> hostValid && $stable(hostData))
      else $error("stream word dropped while stalled");
   chk_done_hold: assert property ($rose(acqDone) |-> acqBusy)
      else $error("done without holding state");
   cover property ($rose(acqDone));
   cover property (hostValid && hostReady);
   cover property (memRdEn);
   cover property (convStart && gapOk_q);
endmodule
bind atc_top atc_top_chk chk (.clock, .rst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .convStart, .rangeSel, .memWrEn, .memWrAddr,
   .memRdEn, .hostValid, .hostData, .hostReady, .acqBusy, .acqDone);
`default_nettype wire

/* File: testbench/atc_store_model.sv */
`default_nettype none
module atc_store_model
   import atc_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic slow, // long read latency
   input wire logic [SMP_W-1:0] level, // analog level
   input wire logic convStart, // converter start
   output logic sampleValid, // samples ready
   output logic [SMP_W-1:0] sampleCh0, // channel 0
   output logic [SMP_W-1:0] sampleCh1, // channel 1
   output logic [SMP_W-1:0] sampleCh2, // channel 2
   output logic [SMP_W-1:0] sampleCh3, // channel 3
   input wire logic memWrEn, // store write
   input wire logic [30:0] memWrAddr, // write address
   input wire logic [31:0] memWrData, // write word
   input wire logic memRdEn, // store read
   input wire logic [30:0] memRdAddr, // read address
   output logic memRdValid, // read answer
   output logic [31:0] memRdData // read word
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] mem [64];
   logic [2:0] convWait = 3'h0;
   logic [2:0] rdWait = 3'h0;
   logic [31:0] rdWord = 32'h0;
   // samples are only meaningful with valid: otherwise show the inverse
   wire [SMP_W-1:0] inv = {SMP_W{!sampleValid}};
   assign sampleCh0 = level ^ inv;
   assign sampleCh1 = (level + 24'h1) ^ inv;
   assign sampleCh2 = (level + 24'h2) ^ inv;
   assign sampleCh3 = (level + 24'h3) ^ inv;
   assign memRdData = memRdValid ? rdWord : ~rdWord;
   initial sampleValid = 1'b0;
   initial memRdValid = 1'b0;
   // converter latency and store: words kept until read back
   always @(posedge clock) begin
      sampleValid <= convWait == 3'h1;
      memRdValid <= rdWait == 3'h1;
      convWait <= convStart ? 3'h2 : convWait - 3'(convWait != 3'h0);
      if (memRdEn) begin
         rdWait <= slow ? 3'h4 : 3'h1;
         rdWord <= mem[memRdAddr[5:0]];
      end else if (rdWait != 3'h0) begin
         rdWait <= rdWait - 3'h1;
      end
      if (memWrEn) begin
         mem[memWrAddr[5:0]] <= memWrData;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/acquisition_trigger_control_test.sv */
`default_nettype none
module acquisition_trigger_control_test
   import atc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic hostReady = 0, slow = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, q, w;
   logic e;
   logic [SMP_W-1:0] level = 24'h000064;
   logic [SMP_W-1:0] pre [4] = '{24'h0, 24'h0, 24'h0, 24'h001388};
   logic [SMP_W-1:0] post [4] = '{24'h0007d0, 24'hfff830, 24'h0007d0, 24'h0};
   wire [31:0] prdata, memWrData, memRdData, hostData;
   wire [30:0] memWrAddr, memRdAddr;
   wire [SMP_W-1:0] sampleCh0, sampleCh1, sampleCh2, sampleCh3;
   wire [15:0] rangeSel;
   wire pready, pslverr, convStart, sampleValid, memWrEn, memRdEn;
   wire memRdValid, hostValid, acqBusy, acqDone;
   int failures = 0, testsRun = 0;
   atc_top dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .convStart, .sampleValid, .sampleCh0,
      .sampleCh1, .sampleCh2, .sampleCh3, .rangeSel, .memWrEn, .memWrAddr,
      .memWrData, .memRdEn, .memRdAddr, .memRdValid, .memRdData,
      .hostValid, .hostData, .hostReady, .acqBusy, .acqDone);
   atc_store_model store (.clock, .slow, .level, .convStart, .sampleValid,
      .sampleCh0, .sampleCh1, .sampleCh2, .sampleCh3, .memWrEn, .memWrAddr,
      .memWrData, .memRdEn, .memRdAddr, .memRdValid, .memRdData);
   always #25 clock = ~clock;
   // one apb transfer; an idle edge follows so calls never collide
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input string nm, input logic [31:0] x, y);
      testsRun++;
      if (y !== x) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, x, y);
      end
   endtask
   task automatic chkReg(input string nm, input logic [7:0] a,
         input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask
   // host side waits for one accepted stream word
   task automatic getWord();
      do begin
         @(posedge clock);
      end while (hostValid !== 1'b1);
      w = hostData;
   endtask
   task automatic waitDone();
      while (acqDone !== 1'b1) @(posedge clock);
   endtask
   function automatic logic [31:0] word(input int ch, input logic [23:0] b);
      return {6'h00, 2'(ch), b + 24'(ch)};
   endfunction
   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // watchdog: tests need about 7000 cycles
   initial begin
      #2000000;
      failures++;
      giveVerdict();
   end
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      chkReg("ctrl", OFF_CTRL, 32'h0);
      chkReg("count", OFF_COUNT, 32'h1);
      chkReg("period", OFF_PERIOD, 32'h14e);
      chkReg("status", OFF_STATUS, 32'h0);
      chkReg("cmd", OFF_CMD, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, 32'(e));
      $display("test reset done");
      apb(1'b1, OFF_RANGE, 32'h9876);
      chk("rangeSel", 32'h9876, 32'(rangeSel));
      apb(1'b1, OFF_RANGE, 32'ha5b4);
      chk("rangeSel", 32'h9574, 32'(rangeSel));
      chkReg("range", OFF_RANGE, 32'h9574);
      $display("test range done");
      apb(1'b1, OFF_CMD, 32'h1);
      repeat (7 * 334) @(posedge clock);
      chkReg("status", OFF_STATUS, 32'h25);
      hostReady <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         getWord();
         chk("stream", word(i % 4, level), w);
      end
      apb(1'b1, OFF_CMD, 32'h2);
      $display("test continuous done");
      apb(1'b1, OFF_CMD, 32'h8);
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_COUNT, 32'h7fffffff);
      chkReg("count", OFF_COUNT, 32'(STORE_SAMPLES_DEF / CHANNELS));
      apb(1'b1, OFF_COUNT, 32'h3);
      apb(1'b1, OFF_PERIOD, 32'h64);
      apb(1'b1, OFF_CMD, 32'h1);
      waitDone();
      chk("acqDone", 32'h1, 32'(acqDone));
      chkReg("status", OFF_STATUS, 32'h33);
      chkReg("stored", OFF_STORED, 32'hc);
      repeat (400) @(posedge clock);
      chk("hostValid", 32'h0, 32'(hostValid));
      for (int i = 0; i < 12; i++) begin
         chk("store", word(i % 4, level), store.mem[i]);
      end
      slow <= 1'b1;
      apb(1'b1, OFF_CMD, 32'h4);
      for (int i = 0; i < 12; i++) begin
         getWord();
         chk("transfer", word(i % 4, level), w);
      end
      repeat (20) @(posedge clock);
      chk("acqBusy", 32'h0, 32'(acqBusy));
      $display("test buffered done");
      apb(1'b1, OFF_HIGH, 32'h3e8);
      apb(1'b1, OFF_LOW, 32'hfffc18);
      apb(1'b1, OFF_COUNT, 32'h2);
      for (int c = 0; c < 4; c++) begin
         level <= pre[c];
         apb(1'b1, OFF_CMD, 32'h8);
         apb(1'b1, OFF_CTRL, 32'h23 | 32'(c << 2));
         apb(1'b1, OFF_CMD, 32'h1);
         repeat (600) @(posedge clock);
         chkReg("status", OFF_STATUS, 32'h11);
         level <= post[c];
         waitDone();
         chkReg("status", OFF_STATUS, 32'h3b);
         chkReg("stored", OFF_STORED, 32'h8);
         chk("first", word(2, post[c]), store.mem[2]);
         apb(1'b1, OFF_CMD, 32'h2);
      end
      $display("test threshold done");
      giveVerdict();
   end
endmodule
`default_nettype wire
